// ---- ssimg_top.sv ----
`timescale 1ns/1ps
// What this block does
// - Plain path bit high while its field free
// - Guarded bit high only if field safe, free
// - Contour bit high when monitor on and contour out of band
// - Per-path flag while waiting for rearm signal
// - Running bit high while protection executes
// - Two signed 16-bit speeds in mm/s
// - Each speed has own validity bit
// - Sleep bit high while in sleep mode
module ssimg_top
    import ssimg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Field evaluation from the scan core
    input wire logic [7:0] plain_field_free,
    input wire logic [7:0] guarded_field_free,
    input wire logic [7:0] guarded_field_safe,
    // Restart interlock per guarded path
    input wire logic [7:0] rearm_enable,
    input wire logic [7:0] rearm_request,
    // Reference contour monitor
    input wire logic contour_monitor_on,
    input wire logic contour_in_band,
    // Operating state
    input wire logic run_active,
    input wire logic sleep_active,
    // Dynamic inputs
    input wire logic signed [15:0] speed_a_in,
    input wire logic speed_a_in_valid,
    input wire logic signed [15:0] speed_b_in,
    input wire logic speed_b_in_valid,
    // Status image
    output logic [7:0] plain_path_free,
    output logic [7:0] guarded_path_free,
    output logic [7:0] path_awaits_rearm,
    output logic contour_out_of_band,
    output logic protection_running,
    output logic sleep_state,
    output logic signed [15:0] velocity_a,
    output logic velocity_a_ok,
    output logic signed [15:0] velocity_b,
    output logic velocity_b_ok
);

    wire [7:0] guarded_nxt;
    wire [7:0] awaits_nxt;
    wire contour_nxt;
    wire force_off;
    wire speed_a_legal;
    wire speed_b_legal;
    wire speed_a_ok_nxt;
    wire speed_b_ok_nxt;
    logic primed_r;

    // Contour loss counts only while the monitor is enabled
    assign contour_nxt = contour_monitor_on && !contour_in_band;
    // Contour loss and paused protection both drop every guarded path output
    assign force_off = contour_nxt || !run_active;

    // Out-of-range words are passed on but never flagged as usable
    assign speed_a_legal = (speed_a_in >= SSIMG_SPEED_MIN) && (speed_a_in <= SSIMG_SPEED_MAX);
    assign speed_b_legal = (speed_b_in >= SSIMG_SPEED_MIN) && (speed_b_in <= SSIMG_SPEED_MAX);

    // Validity needs both the source flag and a legal value
    assign speed_a_ok_nxt = speed_a_in_valid && speed_a_legal;
    assign speed_b_ok_nxt = speed_b_in_valid && speed_b_legal;

    // One interlock slice per guarded path
    genvar gi;
    generate
        for (gi = 0; gi < SSIMG_PATHS; gi++) begin : g_path
            ssimg_path_if pif ();
            assign pif.field_free = guarded_field_free[gi];
            assign pif.field_safe = guarded_field_safe[gi];
            assign pif.force_off = force_off;
            assign pif.rearm_en = rearm_enable[gi];
            assign pif.rearm_req = rearm_request[gi];
            assign guarded_nxt[gi] = pif.guarded_free;
            assign awaits_nxt[gi] = pif.awaits_rearm;
            ssimg_path u_path (
                .clk_sys(clk_sys),
                .rst(rst),
                .p(pif.path)
            );
        end
    endgenerate

    // Single capture point keeps the image coherent to the consumer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            plain_path_free <= SSIMG_PATHS_RST;
            guarded_path_free <= SSIMG_PATHS_RST;
            path_awaits_rearm <= SSIMG_PATHS_RST;
            contour_out_of_band <= SSIMG_BIT_RST;
            protection_running <= SSIMG_BIT_RST;
            sleep_state <= SSIMG_BIT_RST;
            velocity_a <= SSIMG_SPEED_RST;
            velocity_a_ok <= SSIMG_BIT_RST;
            velocity_b <= SSIMG_SPEED_RST;
            velocity_b_ok <= SSIMG_BIT_RST;
            primed_r <= 1'b0;
        end else begin
            plain_path_free <= plain_field_free;
            guarded_path_free <= guarded_nxt;
            path_awaits_rearm <= awaits_nxt;
            contour_out_of_band <= contour_nxt;
            protection_running <= run_active;
            sleep_state <= sleep_active;
            velocity_a <= speed_a_in;
            velocity_a_ok <= speed_a_ok_nxt;
            velocity_b <= speed_b_in;
            velocity_b_ok <= speed_b_ok_nxt;
            primed_r <= 1'b1;
        end
    end

    a_plain_path_copy: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> plain_path_free == $past(plain_field_free))
        else $error("plain path bits do not follow field state");

    a_guarded_needs_free: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> (guarded_path_free & ~$past(guarded_field_free & guarded_field_safe)) == 8'h00)
        else $error("guarded path on without safe free field");

    a_contour_value: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> contour_out_of_band == $past(contour_monitor_on && !contour_in_band))
        else $error("contour bit wrong");

    a_contour_kills_all: assert property (@(posedge clk_sys) disable iff (rst)
        contour_out_of_band |-> guarded_path_free == 8'h00)
        else $error("guarded path on while contour out of band");

    a_rearm_blocks: assert property (@(posedge clk_sys) disable iff (rst)
        (path_awaits_rearm & guarded_path_free) == 8'h00)
        else $error("guarded path on while awaiting rearm");

    a_run_flag: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> protection_running == $past(run_active))
        else $error("running bit wrong");

    a_snapshot_paused: assert property (@(posedge clk_sys) disable iff (rst)
        !protection_running |-> guarded_path_free == 8'h00)
        else $error("image incoherent: paused with guarded path on");

    a_speed_a_range: assert property (@(posedge clk_sys) disable iff (rst)
        velocity_a_ok |-> (velocity_a >= SSIMG_SPEED_MIN && velocity_a <= SSIMG_SPEED_MAX))
        else $error("speed a flagged valid outside range");

    a_speed_b_ok: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> velocity_b_ok == $past(speed_b_in_valid && speed_b_legal))
        else $error("speed b validity wrong");

    a_sleep_flag: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> sleep_state == $past(sleep_active))
        else $error("sleep bit wrong");

    // Exact guarded image whenever nothing forces the paths off
    a_guarded_exact: assert property (@(posedge clk_sys) disable iff (rst)
        (primed_r && $past(run_active && !(contour_monitor_on && !contour_in_band))) |->
            guarded_path_free == ($past(guarded_field_free & guarded_field_safe)
                & ~path_awaits_rearm))
        else $error("guarded path bits wrong");

    // Forcing and contour bit checks, each from its own cause
    a_paused_all_off: assert property (@(posedge clk_sys) disable iff (rst)
        (primed_r && !$past(run_active)) |-> guarded_path_free == 8'h00)
        else $error("guarded path on while protection paused");

    a_contour_forces_off: assert property (@(posedge clk_sys) disable iff (rst)
        (primed_r && $past(contour_monitor_on && !contour_in_band)) |-> guarded_path_free == 8'h00)
        else $error("guarded path on after contour loss");

    a_contour_idle: assert property (@(posedge clk_sys) disable iff (rst)
        (primed_r && !$past(contour_monitor_on)) |-> !contour_out_of_band)
        else $error("contour bit set with monitoring off");

    a_contour_in_band: assert property (@(posedge clk_sys) disable iff (rst)
        (primed_r && $past(contour_in_band)) |-> !contour_out_of_band)
        else $error("contour bit set with contour in band");

    // Interlock flag may only move on its own inputs, two edges back
    a_awaits_rise: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> ((path_awaits_rearm & ~$past(path_awaits_rearm)
            & ~$past(rearm_enable, 2)) == 8'h00))
        else $error("awaits bit rose on a path without interlock");

    a_awaits_clear: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> ((~path_awaits_rearm & $past(path_awaits_rearm)
            & ~$past(rearm_request, 2)) == 8'h00))
        else $error("awaits bit fell without rearm request");

    // Raw speed words and their flags
    a_speed_a_copy: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> velocity_a == $past(speed_a_in))
        else $error("speed a word not passed on");

    a_speed_b_copy: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> velocity_b == $past(speed_b_in))
        else $error("speed b word not passed on");

    a_speed_b_range: assert property (@(posedge clk_sys) disable iff (rst)
        velocity_b_ok |-> (velocity_b >= SSIMG_SPEED_MIN && velocity_b <= SSIMG_SPEED_MAX))
        else $error("speed b flagged valid outside range");

    a_speed_a_ok: assert property (@(posedge clk_sys) disable iff (rst)
        primed_r |-> velocity_a_ok == $past(speed_a_in_valid
            && speed_a_in >= SSIMG_SPEED_MIN && speed_a_in <= SSIMG_SPEED_MAX))
        else $error("speed a validity wrong");

    a_speed_a_invalid: assert property (@(posedge clk_sys) disable iff (rst)
        (primed_r && !$past(speed_a_in_valid)) |-> !velocity_a_ok)
        else $error("speed a valid although source flagged it bad");

    a_speed_b_invalid: assert property (@(posedge clk_sys) disable iff (rst)
        (primed_r && !$past(speed_b_in_valid)) |-> !velocity_b_ok)
        else $error("speed b valid although source flagged it bad");

endmodule

// ---- ssimg_pkg.sv ----
package ssimg_pkg;

    // Image geometry
    localparam int unsigned SSIMG_PATHS = 8;
    localparam int unsigned SSIMG_SPEED_W = 16;

    // Legal speed window in mm/s
    localparam logic signed [15:0] SSIMG_SPEED_MIN = -16'sd32000;
    localparam logic signed [15:0] SSIMG_SPEED_MAX = 16'sd32000;

    // Reset values of the image
    localparam logic [7:0] SSIMG_PATHS_RST = 8'h00;
    localparam logic SSIMG_BIT_RST = 1'b0;
    localparam logic [15:0] SSIMG_SPEED_RST = 16'h0000;
    localparam logic SSIMG_REARM_RST = 1'b0;

endpackage

// ---- ssimg_path_if.sv ----
`timescale 1ns/1ps
interface ssimg_path_if;
    logic field_free;
    logic field_safe;
    logic force_off;
    logic rearm_en;
    logic rearm_req;
    logic guarded_free;
    logic awaits_rearm;

    modport core (
        output field_free,
        output field_safe,
        output force_off,
        output rearm_en,
        output rearm_req,
        input guarded_free,
        input awaits_rearm
    );

    modport path (
        input field_free,
        input field_safe,
        input force_off,
        input rearm_en,
        input rearm_req,
        output guarded_free,
        output awaits_rearm
    );
endinterface

// ---- ssimg_path.sv ----
`timescale 1ns/1ps
module ssimg_path
    import ssimg_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Core side
    ssimg_path_if.path p
);

    logic awaits_r;
    logic awaits_nxt;
    logic primed_r;
    wire path_off;

    // Path is off unless its field is safety-related, free and not forced
    assign path_off = !(p.field_safe && p.field_free) || p.force_off;

    // Setting wins over a rearm arriving in the same cycle
    assign awaits_nxt = (p.rearm_en && path_off) ? 1'b1 :
                        (p.rearm_req && !path_off) ? 1'b0 : awaits_r;

    // Rearm latch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awaits_r <= SSIMG_REARM_RST;
            primed_r <= 1'b0;
        end else begin
            awaits_r <= awaits_nxt;
            primed_r <= 1'b1;
        end
    end

    // A waiting path stays off so a cleared field alone cannot restart it
    assign p.guarded_free = !path_off && !awaits_r;
    assign p.awaits_rearm = awaits_r;

    a_rearm_sets: assert property (@(posedge clk_sys) disable iff (rst)
        (p.rearm_en && path_off) |=> awaits_r)
        else $error("rearm flag not set after interlocked trip");

    a_rearm_holds: assert property (@(posedge clk_sys) disable iff (rst)
        (awaits_r && !p.rearm_req) |=> awaits_r)
        else $error("rearm flag dropped without rearm request");

    a_rearm_clears: assert property (@(posedge clk_sys) disable iff (rst || !primed_r)
        (awaits_r && p.rearm_req && !path_off) |=> !awaits_r)
        else $error("rearm flag not cleared by rearm request");

endmodule

// ---- ssimg_consumer.sv ----
`timescale 1ns/1ps
// Far-end controller: keeps the last speed it was allowed to trust
module ssimg_consumer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Image seen on the network
    input wire logic signed [15:0] velocity_a,
    input wire logic velocity_a_ok,
    // Last trusted speed
    output logic signed [15:0] held_a
);
    // Invalid words are dropped, never used to steer a case switch
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            held_a <= 16'h0000;
        end else if (velocity_a_ok) begin
            held_a <= velocity_a;
        end
    end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import ssimg_pkg::*;
    logic clk_sys, rst, mon, inb, run, slp, va, vb;
    logic [7:0] pff, gff, gfs, ren, rrq, ppf, gpf, par;
    logic signed [15:0] sa, sb, vela, velb, held;
    logic cob, prun, sst, oka, okb;
    int fail_count, cmp_count;
    ssimg_top dut (.clk_sys(clk_sys), .rst(rst), .plain_field_free(pff),
        .guarded_field_free(gff), .guarded_field_safe(gfs), .rearm_enable(ren),
        .rearm_request(rrq), .contour_monitor_on(mon), .contour_in_band(inb),
        .run_active(run), .sleep_active(slp), .speed_a_in(sa), .speed_a_in_valid(va),
        .speed_b_in(sb), .speed_b_in_valid(vb), .plain_path_free(ppf),
        .guarded_path_free(gpf), .path_awaits_rearm(par), .contour_out_of_band(cob),
        .protection_running(prun), .sleep_state(sst), .velocity_a(vela),
        .velocity_a_ok(oka), .velocity_b(velb), .velocity_b_ok(okb));
    ssimg_consumer far (.clk_sys(clk_sys), .rst(rst), .velocity_a(vela),
        .velocity_a_ok(oka), .held_a(held));
    // Inputs move 1 ns after the edge, outputs read there too
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic t_plain();
        pff = 8'ha5;
        step();
        chk("plain", 16'h00a5, ppf);
        pff = 8'h5a;
        step();
        chk("plain", 16'h005a, ppf);
    endtask
    task automatic t_guard();
        gfs = 8'hff;
        gff = 8'h0f;
        run = 1'b1;
        step();
        chk("guarded", 16'h000f, gpf);
        gfs = 8'h03;
        step();
        chk("guarded", 16'h0003, gpf);
        run = 1'b0;
        step();
        chk("running", 16'h0000, prun);
        chk("guarded", 16'h0000, gpf);
        run = 1'b1;
        mon = 1'b1;
        inb = 1'b0;
        step();
        chk("contour", 16'h0001, cob);
        chk("guarded", 16'h0000, gpf);
        chk("running", 16'h0001, prun);
        inb = 1'b1;
        step();
        chk("contour", 16'h0000, cob);
        mon = 1'b0;
        inb = 1'b0;
        step();
        chk("contour", 16'h0000, cob);
        chk("guarded", 16'h0003, gpf);
    endtask
    // Field occupied with interlock armed, then freed, then rearmed
    task automatic t_rearm();
        gfs = 8'hff;
        gff = 8'h00;
        ren = 8'h01;
        step();
        gff = 8'hff;
        step();
        chk("guarded", 16'h00fe, gpf);
        chk("awaits", 16'h0001, par);
        rrq = 8'h01;
        step();
        chk("guarded", 16'h00fe, gpf);
        rrq = 8'h00;
        step();
        chk("guarded", 16'h00ff, gpf);
        chk("awaits", 16'h0000, par);
    endtask
    // Range edges both sides, plus a source that flags its own speed bad
    task automatic t_speed();
        int spd [5] = '{32000, 32001, -32000, -32001, 100};
        for (int i = 0; i < 5; i++) begin
            sa = spd[i][15:0];
            va = (i != 4);
            sb = -spd[i][15:0];
            vb = 1'b1;
            step();
            chk("vel_a", spd[i][15:0], vela);
            chk("ok_a", {15'h0000, (i != 4) && (i % 2 == 0)}, oka);
            chk("vel_b", -spd[i][15:0], velb);
            chk("ok_b", {15'h0000, i % 2 == 0 || i == 4}, okb);
        end
        step();
        chk("held_a", 16'h8300, held);
    endtask
    task automatic t_sleep();
        slp = 1'b1;
        step();
        chk("sleep", 16'h0001, sst);
        slp = 1'b0;
        step();
        chk("sleep", 16'h0000, sst);
    endtask
    // Reset in mid-run clears the image, the first edge after it recaptures
    task automatic t_reset_mid();
        rst = 1'b1;
        step();
        chk("reset_ppf", 16'h0000, ppf);
        chk("reset_gpf", 16'h0000, gpf);
        chk("reset_run", 16'h0000, prun);
        chk("reset_vel_b", 16'h0000, velb);
        chk("reset_ok_b", 16'h0000, okb);
        rst = 1'b0;
        step();
        chk("plain", 16'h005a, ppf);
        chk("guarded", 16'h00ff, gpf);
        chk("vel_b", 16'hff9c, velb);
        chk("ok_b", 16'h0001, okb);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Watchdog well beyond the few dozen cycles the tests need
    initial begin
        #100us;
        fail_count++;
        report_and_stop();
    end
    initial begin
        rst = 1'b1;
        pff = 8'h00;
        gff = 8'h00;
        gfs = 8'h00;
        ren = 8'h00;
        rrq = 8'h00;
        mon = 1'b0;
        inb = 1'b0;
        run = 1'b0;
        slp = 1'b0;
        sa = 16'h0000;
        sb = 16'h0000;
        va = 1'b0;
        vb = 1'b0;
        repeat (5) step();
        chk("reset", 16'h0000, gpf);
        rst = 1'b0;
        t_plain();
        t_guard();
        t_rearm();
        t_speed();
        t_sleep();
        t_reset_mid();
        report_and_stop();
    end
endmodule
